// file: core/dmach_core.sv
// Functional notes
// RULE_01 - Source codes 000 to 011 select timer 0 to timer 3 as the request.
// RULE_02 - Codes 100 and 101 select the first and second serial transmit-empty, 110 the I2C one, 111 nothing.
// RULE_03 - Word bit 0 moves one byte per request, word bit 1 moves two.
// RULE_04 - With interrupt enable set, a pulse is raised once the end-address byte is moved, else none.
// RULE_05 - Direction 0 copies memory to peripheral registers, direction 1 the reverse.
// RULE_06 - With loop clear, the channel clears its enable after the end-address byte.
// RULE_07 - With loop set, the channel reloads the start address after the end byte and keeps going.
// RULE_08 - Enable 1 runs the channel, enable 0 keeps it idle and ignoring requests.
// RULE_09 - Start address is 12 bits with bits 11 to 8 from the low nibble of the high register.
// RULE_10 - End address bits 11 to 8 come from the high nibble of the high register.
// RULE_11 - Start address bits 7 to 0 come from a read/write start low register.
// RULE_12 - End address bits 7 to 0 come from a read/write end low register.
// RULE_13 - The peripheral register address is the peripheral low byte on page F.
// RULE_14 - Reading the start low register returns the current transfer address low byte.
// RULE_15 - The current address steps by one per byte up to the end, pairs use consecutive addresses.
// RULE_16 - One transfer starts per rising edge of the selected request, never while one is running.
`timescale 1ns/100ps

module dmach_core (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [11:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_ack,
    input  wire logic [3:0]  timer_req,
    input  wire logic [1:0]  serial_tx_empty,
    input  wire logic        i2c_tx_empty,
    output logic             dma_irq,
    output logic             busy
);

    // ==================================================
    // Reset release
    logic       rst_meta;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ==================================================
    // Registers
    logic [7:0]  channel_control_reg;
    logic [7:0]  peripheral_addr_low_reg;
    logic [7:0]  address_high_nibble_reg;
    logic [7:0]  start_current_low_reg;
    logic [7:0]  end_addr_low_reg;
    logic [11:0] cur_addr;
    logic [7:0]  data_buf;
    logic        byte_idx;
    logic        req_prev;
    logic        pending;
    dmach_pkg::dmach_state_e state;
    dmach_pkg::dmach_state_e next_state;

    wire        ch_en    = channel_control_reg[dmach_pkg::BIT_EN];
    wire        ch_loop  = channel_control_reg[dmach_pkg::BIT_LOOP];
    wire        ch_dir   = channel_control_reg[dmach_pkg::BIT_DIR];
    wire        ch_ien   = channel_control_reg[dmach_pkg::BIT_IEN];
    wire        ch_word  = channel_control_reg[dmach_pkg::BIT_WORD];
    wire [2:0]  ch_src   = channel_control_reg[dmach_pkg::SRC_MSB:dmach_pkg::SRC_LSB];

    wire        wr_ctrl   = reg_wr && (reg_addr == dmach_pkg::OFS_CTRL);
    wire        wr_periph = reg_wr && (reg_addr == dmach_pkg::OFS_PERIPH_LO);
    wire        wr_hi     = reg_wr && (reg_addr == dmach_pkg::OFS_HI_NIB);
    wire        wr_start  = reg_wr && (reg_addr == dmach_pkg::OFS_START_LO);
    wire        wr_end    = reg_wr && (reg_addr == dmach_pkg::OFS_END_LO);

    // ==================================================
    // Address formation
    wire [11:0] start_full = {address_high_nibble_reg[dmach_pkg::HI_START_MSB:dmach_pkg::HI_START_LSB], // RULE_09
                              start_current_low_reg};                                                  // RULE_11
    wire [11:0] end_full   = {address_high_nibble_reg[dmach_pkg::HI_END_MSB:dmach_pkg::HI_END_LSB],     // RULE_10
                              end_addr_low_reg};                                                       // RULE_12
    wire [7:0]  periph_lo  = peripheral_addr_low_reg + {7'h00, byte_idx};
    wire [11:0] periph_full = {dmach_pkg::PERIPH_PAGE, periph_lo};  // RULE_13
    wire [11:0] src_addr   = ch_dir ? periph_full : cur_addr;      // RULE_05
    wire [11:0] dst_addr   = ch_dir ? cur_addr : periph_full;      // RULE_05

    // ==================================================
    // Request selection
    wire        sel_req = (ch_src == dmach_pkg::SRC_TIMER0)  ? timer_req[0] :         // RULE_01
                          (ch_src == dmach_pkg::SRC_TIMER1)  ? timer_req[1] :         // RULE_01
                          (ch_src == dmach_pkg::SRC_TIMER2)  ? timer_req[2] :         // RULE_01
                          (ch_src == dmach_pkg::SRC_TIMER3)  ? timer_req[3] :         // RULE_01
                          (ch_src == dmach_pkg::SRC_SERIAL0) ? serial_tx_empty[0] :   // RULE_02
                          (ch_src == dmach_pkg::SRC_SERIAL1) ? serial_tx_empty[1] :   // RULE_02
                          (ch_src == dmach_pkg::SRC_I2C)     ? i2c_tx_empty :         // RULE_02
                          1'b0;
    // Edges during a transfer are held in one pending slot, not counted
    wire        req_edge  = ch_en && sel_req && !req_prev;          // RULE_16
    wire        start_xfr = (state == dmach_pkg::DMACH_IDLE) && ch_en && pending;  // RULE_08
    wire        next_pending = ch_en && (req_edge || (pending && !start_xfr));

    wire        byte_done = (state == dmach_pkg::DMACH_WRITE) && mem_ack;
    wire        at_end    = (cur_addr == end_full);
    wire        end_done  = byte_done && at_end;
    wire        more_pair = byte_done && !at_end && ch_word && !byte_idx;  // RULE_03

    // ==================================================
    // Transfer sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            dmach_pkg::DMACH_IDLE: begin
                if (start_xfr) begin
                    next_state = dmach_pkg::DMACH_READ;
                end
            end
            dmach_pkg::DMACH_READ: begin
                if (mem_ack) begin
                    next_state = dmach_pkg::DMACH_WRITE;
                end
            end
            dmach_pkg::DMACH_WRITE: begin
                if (mem_ack) begin
                    next_state = more_pair ? dmach_pkg::DMACH_READ : dmach_pkg::DMACH_IDLE;
                end
            end
            // Unused fourth code falls back to idle
            default: begin
                next_state = dmach_pkg::DMACH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state    <= dmach_pkg::DMACH_IDLE;
            req_prev <= 1'b0;
            pending  <= 1'b0;
        end else begin
            state    <= next_state;
            req_prev <= sel_req;
            pending  <= next_pending;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            byte_idx <= 1'b0;
            data_buf <= 8'h00;
        end else begin
            if (start_xfr) begin
                byte_idx <= 1'b0;
            end else if (more_pair) begin
                byte_idx <= 1'b1;           // RULE_03
            end
            if ((state == dmach_pkg::DMACH_READ) && mem_ack) begin
                data_buf <= mem_rdata;
            end
        end
    end

    // Current address follows the start while parked, so a read shows the start
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_addr <= 12'h000;
        end else if (end_done && ch_loop) begin
            cur_addr <= start_full;         // RULE_07
        end else if (byte_done && !at_end) begin
            cur_addr <= cur_addr + 12'h001; // RULE_15
        end else if (!ch_en && (state == dmach_pkg::DMACH_IDLE)) begin
            cur_addr <= start_full;
        end
    end

    // ==================================================
    // Software registers; a software write beats the hardware disable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            channel_control_reg <= dmach_pkg::RST_CTRL;
        end else if (wr_ctrl) begin
            channel_control_reg <= reg_wdata;  // RULE_08
        end else if (end_done && !ch_loop) begin
            channel_control_reg[dmach_pkg::BIT_EN] <= 1'b0;  // RULE_06
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            peripheral_addr_low_reg <= dmach_pkg::RST_PERIPH_LO;
            address_high_nibble_reg <= dmach_pkg::RST_HI_NIB;
            start_current_low_reg   <= dmach_pkg::RST_START_LO;
            end_addr_low_reg        <= dmach_pkg::RST_END_LO;
        end else begin
            if (wr_periph) begin
                peripheral_addr_low_reg <= reg_wdata;
            end
            if (wr_hi) begin
                address_high_nibble_reg <= reg_wdata;
            end
            if (wr_start) begin
                start_current_low_reg <= reg_wdata;  // RULE_11
            end
            if (wr_end) begin
                end_addr_low_reg <= reg_wdata;       // RULE_12
            end
        end
    end

    // ==================================================
    // Read port, one cycle after the strobe; unmapped reads give zero
    wire [7:0] rd_mux = (reg_addr == dmach_pkg::OFS_CTRL)      ? channel_control_reg :
                        (reg_addr == dmach_pkg::OFS_PERIPH_LO) ? peripheral_addr_low_reg :
                        (reg_addr == dmach_pkg::OFS_HI_NIB)    ? address_high_nibble_reg :
                        (reg_addr == dmach_pkg::OFS_START_LO)  ? cur_addr[7:0] :  // RULE_14
                        (reg_addr == dmach_pkg::OFS_END_LO)    ? end_addr_low_reg :
                        8'h00;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
            dma_irq    <= 1'b0;
        end else begin
            reg_rdata  <= reg_rd ? rd_mux : 8'h00;
            reg_rvalid <= reg_rd;
            dma_irq    <= end_done && ch_ien;  // RULE_04
        end
    end

    // ==================================================
    // Master side
    assign mem_req   = (state != dmach_pkg::DMACH_IDLE);
    assign mem_we    = (state == dmach_pkg::DMACH_WRITE);
    assign mem_addr  = mem_we ? dst_addr : src_addr;
    assign mem_wdata = data_buf;
    assign busy      = mem_req;

    // ==================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence rd_beat;
        (state == dmach_pkg::DMACH_READ) && mem_ack;
    endsequence

    sequence wr_beat;
        (state == dmach_pkg::DMACH_WRITE) && mem_ack;
    endsequence

    timer_select_a: assert property (  // RULE_01
        (ch_src == dmach_pkg::SRC_TIMER2) |-> (sel_req == timer_req[2]))
        else $error("Timer source not selected");

    flag_select_a: assert property (  // RULE_02
        ((ch_src != dmach_pkg::SRC_RSVD) || !sel_req) &&
        ((ch_src != dmach_pkg::SRC_SERIAL1) || (sel_req == serial_tx_empty[1])))
        else $error("Flag source select wrong");

    pair_count_a: assert property (  // RULE_03
        wr_beat ##0 !ch_word |=> (state == dmach_pkg::DMACH_IDLE))
        else $error("Byte mode moved a second byte");

    irq_pulse_a: assert property (  // RULE_04
        wr_beat ##0 at_end |=> (dma_irq == $past(ch_ien)))
        else $error("End interrupt wrong");

    dir_route_a: assert property (  // RULE_05
        (state == dmach_pkg::DMACH_READ) && !ch_dir |-> (mem_addr == cur_addr) && !mem_we)
        else $error("Memory not the source");

    stop_at_end_a: assert property (  // RULE_06
        wr_beat ##0 (at_end && !ch_loop && !wr_ctrl) |=> !ch_en)
        else $error("Channel did not disable at end");

    loop_reload_a: assert property (  // RULE_07
        wr_beat ##0 (at_end && ch_loop) |=> (cur_addr == $past(start_full)) && ch_en)
        else $error("Loop reload failed");

    idle_when_off_a: assert property (  // RULE_08
        !ch_en && (state == dmach_pkg::DMACH_IDLE) |=> (state == dmach_pkg::DMACH_IDLE))
        else $error("Disabled channel started");

    start_form_a: assert property (  // RULE_09
        start_full[11:8] == address_high_nibble_reg[3:0])
        else $error("Start high bits wrong");

    end_form_a: assert property (  // RULE_10
        end_full == {address_high_nibble_reg[7:4], end_addr_low_reg})
        else $error("End address form wrong");

    start_write_a: assert property (  // RULE_11
        wr_start |=> (start_current_low_reg == $past(reg_wdata)))
        else $error("Start low write lost");

    end_write_a: assert property (  // RULE_12
        wr_end |=> (end_addr_low_reg == $past(reg_wdata)))
        else $error("End low write lost");

    periph_page_a: assert property (  // RULE_13
        mem_we && !ch_dir |-> (mem_addr[11:8] == 4'hf))
        else $error("Peripheral page wrong");

    current_read_a: assert property (  // RULE_14
        reg_rd && (reg_addr == dmach_pkg::OFS_START_LO) |=> (reg_rdata == $past(cur_addr[7:0])))
        else $error("Current address readback wrong");

    addr_step_a: assert property (  // RULE_15
        wr_beat ##0 !at_end |=> (cur_addr == $past(cur_addr) + 12'h001))
        else $error("Address did not step");

    one_start_a: assert property (  // RULE_16
        start_xfr |=> !start_xfr ##0 (state == dmach_pkg::DMACH_READ))
        else $error("Transfer restarted early");

    read_then_write_a: assert property (  // RULE_05
        rd_beat |=> mem_we ##0 (mem_wdata == $past(mem_rdata)))
        else $error("Read data not forwarded");

    irq_quiet_a: assert property (  // RULE_04
        !end_done |=> !dma_irq)
        else $error("Interrupt without end byte");

    pair_second_a: assert property (  // RULE_03
        wr_beat ##0 (ch_word && !byte_idx && !at_end) |=> (state == dmach_pkg::DMACH_READ) && byte_idx)
        else $error("Second byte of pair not started");

    req_ignored_a: assert property (  // RULE_08
        !ch_en |=> !pending)
        else $error("Request kept while disabled");

    pending_hold_a: assert property (  // RULE_16
        req_edge && busy |=> pending)
        else $error("Request during transfer lost");

endmodule

// file: core/dmach_pkg.sv
package dmach_pkg;

    // ==================================================
    // Register offsets in the register file
    localparam logic [11:0] OFS_CTRL      = 12'hfb8;
    localparam logic [11:0] OFS_PERIPH_LO = 12'hfb9;
    localparam logic [11:0] OFS_HI_NIB    = 12'hfba;
    localparam logic [11:0] OFS_START_LO  = 12'hfbb;
    localparam logic [11:0] OFS_END_LO    = 12'hfbc;

    // ==================================================
    // Control register fields
    localparam int BIT_EN       = 7;
    localparam int BIT_LOOP     = 6;
    localparam int BIT_DIR      = 5;
    localparam int BIT_IEN      = 4;
    localparam int BIT_WORD     = 3;
    localparam int SRC_MSB      = 2;
    localparam int SRC_LSB      = 0;

    // High nibble register fields
    localparam int HI_START_MSB = 3;
    localparam int HI_START_LSB = 0;
    localparam int HI_END_MSB   = 7;
    localparam int HI_END_LSB   = 4;

    // ==================================================
    // Reset values
    localparam logic [7:0] RST_CTRL      = 8'h00;
    localparam logic [7:0] RST_PERIPH_LO = 8'h00;
    localparam logic [7:0] RST_HI_NIB    = 8'h00;
    localparam logic [7:0] RST_START_LO  = 8'h00;
    localparam logic [7:0] RST_END_LO    = 8'h00;

    // Peripheral control page
    localparam logic [3:0] PERIPH_PAGE   = 4'hf;

    // ==================================================
    // Request source codes
    localparam logic [2:0] SRC_TIMER0  = 3'h0;
    localparam logic [2:0] SRC_TIMER1  = 3'h1;
    localparam logic [2:0] SRC_TIMER2  = 3'h2;
    localparam logic [2:0] SRC_TIMER3  = 3'h3;
    localparam logic [2:0] SRC_SERIAL0 = 3'h4;
    localparam logic [2:0] SRC_SERIAL1 = 3'h5;
    localparam logic [2:0] SRC_I2C     = 3'h6;
    localparam logic [2:0] SRC_RSVD    = 3'h7;

    typedef enum logic [1:0] {
        DMACH_IDLE,
        DMACH_READ,
        DMACH_WRITE
    } dmach_state_e;

endpackage

// file: tb/dma_channel_regfile_peripheral_bench.sv
`timescale 1ns/100ps

module dma_channel_regfile_peripheral_bench;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic        mem_req;
    logic        mem_we;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic        mem_ack;
    logic [6:0]  src_vec = 7'h00;
    logic        dma_irq;
    logic        busy;
    logic [3:0]  ack_delay = 4'h0;
    logic [31:0] seed = 32'h0001_743e;
    logic [7:0]  exp_q [$];
    logic [7:0]  d0;
    logic [7:0]  d1;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          irq_cnt = 0;

    // ==================================================
    // Clock, design and far side
    always #4 clk_sys = ~clk_sys;

    dmach_core dmach_core_i (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .timer_req(src_vec[3:0]),
        .serial_tx_empty(src_vec[5:4]), .i2c_tx_empty(src_vec[6]), .dma_irq(dma_irq), .busy(busy));

    dmach_far_model dmach_far_model_i (.clk_sys(clk_sys), .rstn(rstn), .ack_delay(ack_delay),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    // ==================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expect_v);
        total_checks++;
        if (seen !== expect_v) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, expect_v, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
    endtask

    // Expected value is noted here, compared when the answer shows
    task automatic reg_read(input logic [11:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd   = 1'b1;
        exp_q.push_back(e);
        @(negedge clk_sys);
        reg_rd   = 1'b0;
        @(negedge clk_sys);
    endtask

    always @(negedge clk_sys) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected read", reg_rdata, 8'hxx);
            end else begin
                check("read data", reg_rdata, exp_q.pop_front());
            end
        end
        if (dma_irq === 1'b1) begin
            irq_cnt++;
        end
    end

    task automatic pulse(input logic [6:0] v);
        @(negedge clk_sys);
        src_vec = v;
        @(negedge clk_sys);
        src_vec = 7'h00;
    endtask

    // Bounded waits: start within a few cycles, finish within 200
    task automatic run_req(input logic [6:0] v);
        int i;
        pulse(v);
        for (i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk_sys);
        check("transfer start", {7'h00, busy}, 8'h01);
        if (busy !== 1'b1) begin
            tally_and_finish();
        end
        for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk_sys);
        check("transfer end", {7'h00, busy}, 8'h00);
        if (busy !== 1'b0) begin
            tally_and_finish();
        end
        // Let the end pulse be counted before anyone reads the count
        @(negedge clk_sys);
    endtask

    task automatic no_run(input logic [6:0] v);
        pulse(v);
        repeat (8) begin
            @(negedge clk_sys);
            check("busy idle", {7'h00, busy}, 8'h00);
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        tally_and_finish();
    end

    // ==================================================
    // Main sequence
    initial begin
        int k;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (k = 0; k < 5; k++) reg_read(dmach_pkg::OFS_CTRL + 12'(k), 8'h00);
        reg_write(12'hfbd, 8'hff);
        reg_read(12'hfbd, 8'h00);
        reg_write(dmach_pkg::OFS_END_LO, 8'ha5);
        reg_read(dmach_pkg::OFS_END_LO, 8'ha5);
        // One byte memory to peripheral for every live source code
        for (k = 0; k < 7; k++) begin
            seed = lfsr_next(seed);
            d0 = seed[7:0];
            dmach_far_model_i.mem[{4'h2, 8'h10 + 8'(k)}] = d0;
            reg_write(dmach_pkg::OFS_HI_NIB, 8'h22);
            reg_write(dmach_pkg::OFS_START_LO, 8'h10 + 8'(k));
            reg_write(dmach_pkg::OFS_END_LO, 8'h10 + 8'(k));
            reg_write(dmach_pkg::OFS_PERIPH_LO, 8'h30 + 8'(k));
            reg_write(dmach_pkg::OFS_CTRL, 8'h90 | 8'(k));
            no_run(7'h7f & ~(7'h01 << k));
            run_req(7'h01 << k);
            check("periph byte", dmach_far_model_i.mem[{4'hf, 8'h30 + 8'(k)}], d0);
            check("irq count", 8'(irq_cnt), 8'(k + 1));
            reg_read(dmach_pkg::OFS_CTRL, 8'h10 | 8'(k));
        end
        reg_write(dmach_pkg::OFS_CTRL, 8'h87);
        no_run(7'h7f);
        reg_write(dmach_pkg::OFS_CTRL, 8'h01);
        no_run(7'h02);
        // Word move peripheral to memory with a slow far side
        ack_delay = 4'h3;
        seed = lfsr_next(seed);
        d0 = seed[7:0];
        d1 = seed[15:8];
        dmach_far_model_i.mem[12'hf50] = d0;
        dmach_far_model_i.mem[12'hf51] = d1;
        reg_write(dmach_pkg::OFS_HI_NIB, 8'h11);
        reg_write(dmach_pkg::OFS_START_LO, 8'h23);
        reg_write(dmach_pkg::OFS_END_LO, 8'h24);
        reg_write(dmach_pkg::OFS_PERIPH_LO, 8'h50);
        reg_write(dmach_pkg::OFS_CTRL, 8'hb8);
        run_req(7'h01);
        check("word byte0", dmach_far_model_i.mem[12'h123], d0);
        check("word byte1", dmach_far_model_i.mem[12'h124], d1);
        check("irq count", 8'(irq_cnt), 8'h08);
        // Looping single bytes, no interrupt
        ack_delay = 4'h1;
        dmach_far_model_i.mem[12'h340] = 8'h3c;
        dmach_far_model_i.mem[12'h341] = 8'hc3;
        reg_write(dmach_pkg::OFS_HI_NIB, 8'h33);
        reg_write(dmach_pkg::OFS_START_LO, 8'h40);
        reg_write(dmach_pkg::OFS_END_LO, 8'h41);
        reg_write(dmach_pkg::OFS_PERIPH_LO, 8'h60);
        reg_write(dmach_pkg::OFS_CTRL, 8'hc1);
        run_req(7'h02);
        reg_read(dmach_pkg::OFS_START_LO, 8'h41);
        run_req(7'h02);
        check("loop byte", dmach_far_model_i.mem[12'hf60], 8'hc3);
        reg_read(dmach_pkg::OFS_START_LO, 8'h40);
        reg_read(dmach_pkg::OFS_CTRL, 8'hc1);
        run_req(7'h02);
        check("loop again", dmach_far_model_i.mem[12'hf60], 8'h3c);
        check("irq count", 8'(irq_cnt), 8'h08);
        repeat (4) @(negedge clk_sys);
        check("reads left", 8'(exp_q.size()), 8'h00);
        tally_and_finish();
    end
endmodule

// file: tb/dmach_far_model.sv
`timescale 1ns/100ps

// ==================================================
// Register file and peripheral registers behind the channel
module dmach_far_model (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [3:0]  ack_delay,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [11:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata,
    output logic             mem_ack
);
    logic [7:0] mem [0:4095];
    logic [3:0] wait_cnt;

    // Read data toggles outside the answer cycle, so a stale sample shows up
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            mem_rdata <= 8'h5a;
        end else if (mem_ack) begin
            mem_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            mem_rdata <= ~mem_rdata;
            if (mem_we) begin
                mem[mem_addr] <= mem_wdata;
            end
        end else if (mem_req && wait_cnt >= ack_delay) begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr];
        end else begin
            wait_cnt  <= mem_req ? wait_cnt + 4'h1 : 4'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule
